/* File: doc_chk.sv */
// Port assertions for the output update control.
// Bound into every instance; INIT_CYCLES follows the design's value.
`timescale 1ns/10ps
`default_nettype none
module doc_chk #(
	parameter int INIT_CYCLES = 4
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic linkSelN,
	input wire logic statusIndicator,
	input wire logic [7:0][11:0] dacCode,
	input wire logic [7:0] dacLoad,
	input wire logic [1:0] rangeHigh,
	input wire logic updateMode,
	input wire logic [2:0] rangeConfig,
	input wire logic rdMode
);
	logic [9:0] upCnt;
	logic [9:0] next_upCnt;
	// Saturates so a long run never wraps back into startup
	always_comb
	begin
		next_upCnt = (upCnt == 10'h3FF) ? upCnt : upCnt + 10'h001;
	end
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			upCnt <= 10'h000;
		else
			upCnt <= next_upCnt;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence selIdle;
		linkSelN [*6];
	endsequence
	sequence selBusy;
		!linkSelN [*5];
	endsequence
	init_lit_a: assert property (upCnt < INIT_CYCLES |-> statusIndicator)
		else $error("indicator dark in startup");
	idle_dark_a: assert property (selIdle ##0 (upCnt > INIT_CYCLES + 3)
		|-> !statusIndicator) else $error("indicator lit when idle");
	busy_lit_a: assert property (selBusy |-> statusIndicator)
		else $error("indicator dark in frame");
	reset_vals_a: assert property ($fell(rst) |-> dacCode == '0
		&& !updateMode && rangeConfig == 3'h2) else $error("bad reset state");
	async_one_a: assert property (!updateMode |-> $onehot0(dacLoad))
		else $error("multi load in async");
	sync_load_a: assert property (updateMode |-> dacLoad inside {8'h00, 8'hFF})
		else $error("partial load in sync");
	load_pulse_a: assert property (dacLoad != 8'h00 |=> dacLoad == 8'h00)
		else $error("load longer than a cycle");
	code_hold_a: assert property (dacLoad == 8'h00 |-> $stable(dacCode))
		else $error("code moved without load");
	range_hi_a: assert property (rangeHigh == (rangeConfig > 3'h2 ? 2'h3 : 2'h2))
		else $error("bad upper range");
	rd_mode_a: assert property (rdMode == $past(updateMode))
		else $error("mode readback wrong");
endmodule
bind doc_dac_update_ctrl doc_chk #(.INIT_CYCLES(INIT_CYCLES)) chk (
	.sys_clk(sys_clk), .rst(rst), .linkSelN(linkSelN),
	.statusIndicator(statusIndicator), .dacCode(dacCode), .dacLoad(dacLoad),
	.rangeHigh(rangeHigh), .updateMode(updateMode),
	.rangeConfig(rangeConfig), .rdMode(rdMode)
);
`default_nettype wire

/* File: doc_dac_update_ctrl.sv */
// Output update control: serial frame receiver, code holding, strobe, calibration.
// Link pins come from the master's domain and are synchronised before use.
`timescale 1ns/10ps
`default_nettype none
module doc_dac_update_ctrl #(
	parameter int INIT_CYCLES = doc_pkg::INIT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic linkClk,
	input wire logic linkSelN,
	input wire logic linkData,
	input wire logic [2:0] rdChannel,
	output logic statusIndicator,
	output logic [7:0][11:0] dacCode,
	output logic [7:0] dacLoad,
	output logic [1:0] rangeLow,
	output logic [1:0] rangeHigh,
	output logic updateMode,
	output logic [2:0] rangeConfig,
	output logic [15:0] rdGain,
	output logic [15:0] rdOffset,
	output logic rdMode
);
	if (INIT_CYCLES < 1 || INIT_CYCLES > 65535)
		$error("INIT_CYCLES must lie in 1..65535");

	// Range of one channel under a configuration code
	function automatic logic [1:0] rangeOf(input logic [2:0] cfg,
		input logic [2:0] ch);
		logic lowPair;
		lowPair = (ch < 3'h2);
		case (cfg)
			3'h0: rangeOf = lowPair ? doc_pkg::RANGE_2V5 : doc_pkg::RANGE_10V;
			3'h1: rangeOf = lowPair ? doc_pkg::RANGE_5V : doc_pkg::RANGE_10V;
			3'h2: rangeOf = doc_pkg::RANGE_10V;
			3'h3: rangeOf = lowPair ? doc_pkg::RANGE_5V : doc_pkg::RANGE_20V;
			3'h4: rangeOf = lowPair ? doc_pkg::RANGE_10V : doc_pkg::RANGE_20V;
			3'h5: rangeOf = doc_pkg::RANGE_20V;
			default: rangeOf = doc_pkg::RANGE_10V;
		endcase
	endfunction

	// Link receiver state
	logic [2:0] clkSync;
	logic [1:0] selSync;
	logic [1:0] datSync;
	logic [31:0] shiftReg;
	logic [5:0] bitCnt;
	logic frameDone;
	logic [31:0] frame;
	logic [31:0] next_shiftReg;
	logic [5:0] next_bitCnt;
	logic next_frameDone;
	logic [31:0] next_frame;
	logic clkRise;
	logic selActive;

	assign clkRise = clkSync[1] & ~clkSync[2];
	assign selActive = ~selSync[1];

	always_comb
	begin
		next_shiftReg = shiftReg;
		next_bitCnt = bitCnt;
		next_frameDone = 1'b0;
		next_frame = frame;
		// Dropping select mid-frame discards the partial frame
		if (!selActive)
		begin
			next_bitCnt = '0;
		end
		else if (clkRise)
		begin
			next_shiftReg = {shiftReg[30:0], datSync[1]};
			if (bitCnt == 6'(doc_pkg::FRAME_W - 1))
			begin
				next_bitCnt = '0;
				next_frameDone = 1'b1;
				next_frame = {shiftReg[30:0], datSync[1]};
			end
			else
			begin
				next_bitCnt = bitCnt + 6'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			clkSync <= 3'h0;
			selSync <= 2'h3;
			datSync <= 2'h0;
			shiftReg <= 32'h00000000;
			bitCnt <= 6'h00;
			frameDone <= 1'b0;
			frame <= 32'h00000000;
		end
		else
		begin
			clkSync <= {clkSync[1:0], linkClk};
			selSync <= {selSync[0], linkSelN};
			datSync <= {datSync[0], linkData};
			shiftReg <= next_shiftReg;
			bitCnt <= next_bitCnt;
			frameDone <= next_frameDone;
			frame <= next_frame;
		end
	end

	// Core state
	doc_pkg::doc_state_e state;
	doc_pkg::doc_state_e next_state;
	logic [15:0] initCnt;
	logic [15:0] next_initCnt;
	logic [11:0] held [8];
	logic [11:0] next_held [8];
	logic [15:0] calGain [4][8];
	logic [15:0] calOffset [4][8];
	logic [15:0] next_calGain [4][8];
	logic [15:0] next_calOffset [4][8];
	logic [7:0][11:0] next_dacCode;
	logic [7:0] next_dacLoad;
	logic next_updateMode;
	logic [2:0] next_rangeConfig;
	logic next_statusIndicator;
	logic [1:0] next_rangeLow;
	logic [1:0] next_rangeHigh;
	logic [15:0] next_rdGain;
	logic [15:0] next_rdOffset;
	logic [3:0] op;
	logic [2:0] ch;
	logic [15:0] data;
	logic [1:0] calRange;
	logic [1:0] rdRange;

	assign op = frame[doc_pkg::F_OP_HI:doc_pkg::F_OP_LO];
	assign ch = frame[doc_pkg::F_CH_HI:doc_pkg::F_CH_LO];
	assign data = frame[doc_pkg::F_DATA_HI:doc_pkg::F_DATA_LO];
	assign calRange = rangeOf(rangeConfig, ch);
	assign rdRange = rangeOf(rangeConfig, rdChannel);

	always_comb
	begin
		next_state = state;
		next_initCnt = initCnt;
		next_held = held;
		next_calGain = calGain;
		next_calOffset = calOffset;
		next_dacCode = dacCode;
		next_dacLoad = 8'h00;
		next_updateMode = updateMode;
		next_rangeConfig = rangeConfig;
		case (state)
			doc_pkg::ST_INIT:
			begin
				if (initCnt == 16'(INIT_CYCLES - 1))
					next_state = doc_pkg::ST_RUN;
				else
					next_initCnt = initCnt + 16'h0001;
			end
			doc_pkg::ST_RUN:
			begin
				// Frames that land during startup are dropped
				if (frameDone)
				begin
					case (op)
						doc_pkg::OP_WRITE_CODE:
						begin
							if (data <= doc_pkg::CODE_MAX)
							begin
								next_held[ch] = data[11:0];
								if (updateMode == doc_pkg::MODE_ASYNC)
								begin
									next_dacCode[ch] = data[11:0];
									next_dacLoad[ch] = 1'b1;
								end
							end
						end
						doc_pkg::OP_UPDATE_ALL_STROBE:
						begin
							if (updateMode == doc_pkg::MODE_SYNC)
							begin
								for (int i = 0; i < doc_pkg::CHANNELS; i++)
									next_dacCode[i] = held[i];
								next_dacLoad = 8'hFF;
							end
						end
						doc_pkg::OP_OUTPUT_CONFIG:
						begin
							// Out-of-table range codes leave the range alone
							if (data[2:0] <= doc_pkg::CFG_MAX)
								next_rangeConfig = data[2:0];
							next_updateMode = data[doc_pkg::F_MODE];
						end
						doc_pkg::OP_CALIBRATE_CHANNEL:
						begin
							// Only the entry of the channel's current range moves
							if (frame[doc_pkg::F_CAL_SEL])
								next_calOffset[calRange][ch] = data;
							else
								next_calGain[calRange][ch] = data;
						end
						default:
						begin
						end
					endcase
				end
			end
			default:
			begin
				next_state = doc_pkg::ST_INIT;
			end
		endcase
		next_statusIndicator = (next_state == doc_pkg::ST_INIT)
			| selActive;
		next_rangeLow = rangeOf(next_rangeConfig, 3'h0);
		next_rangeHigh = rangeOf(next_rangeConfig, 3'h2);
		next_rdGain = calGain[rdRange][rdChannel];
		next_rdOffset = calOffset[rdRange][rdChannel];
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state <= doc_pkg::ST_INIT;
			initCnt <= 16'h0000;
			for (int i = 0; i < doc_pkg::CHANNELS; i++)
			begin
				held[i] <= doc_pkg::CODE_RESET;
				for (int r = 0; r < doc_pkg::RANGES; r++)
				begin
					// Measured constants for 0-10 V, typical for the rest
					if (r == doc_pkg::RANGE_10V)
					begin
						calGain[r][i] <= doc_pkg::GAIN_MEASURED;
						calOffset[r][i] <= doc_pkg::OFFSET_MEASURED;
					end
					else
					begin
						calGain[r][i] <= doc_pkg::GAIN_TYPICAL;
						calOffset[r][i] <= doc_pkg::OFFSET_TYPICAL;
					end
				end
			end
			dacCode <= '0;
			dacLoad <= 8'h00;
			updateMode <= doc_pkg::MODE_ASYNC;
			rangeConfig <= doc_pkg::CFG_RESET;
			statusIndicator <= 1'b1;
			rangeLow <= doc_pkg::RANGE_10V;
			rangeHigh <= doc_pkg::RANGE_10V;
			rdGain <= 16'h0000;
			rdOffset <= 16'h0000;
			rdMode <= doc_pkg::MODE_ASYNC;
		end
		else
		begin
			state <= next_state;
			initCnt <= next_initCnt;
			held <= next_held;
			calGain <= next_calGain;
			calOffset <= next_calOffset;
			dacCode <= next_dacCode;
			dacLoad <= next_dacLoad;
			updateMode <= next_updateMode;
			rangeConfig <= next_rangeConfig;
			statusIndicator <= next_statusIndicator;
			rangeLow <= next_rangeLow;
			rangeHigh <= next_rangeHigh;
			rdGain <= next_rdGain;
			rdOffset <= next_rdOffset;
			rdMode <= updateMode;
		end
	end
endmodule
`default_nettype wire

/* File: doc_link_master.sv */
// Serial link master model: MSB-first frames, 125 ns bit clock.
// Clock stands still between frames; data shows junk when deselected.
`timescale 1ns/10ps
`default_nettype none
module doc_link_master (
	output logic linkClk,
	output logic linkSelN,
	output logic linkData
);
	initial
	begin
		linkClk = 1'b0;
		linkSelN = 1'b1;
		linkData = 1'b0;
	end
	// Fewer than 32 bits aborts the frame mid-way
	task automatic send(input logic [31:0] f, input int bits);
		int i;
		linkSelN = 1'b0;
		for (i = 31; i > 31 - bits; i--)
		begin
			linkData = f[i];
			#62.5 linkClk = 1'b1;
			#62.5 linkClk = 1'b0;
		end
		linkSelN = 1'b1;
		linkData = ~linkData;
	endtask
endmodule
`default_nettype wire

/* File: doc_pkg.sv */
// Constants, codes and field layout for the eight-channel output update control.
// Assumes a single system clock; the serial link is sampled, not clocked from.
package doc_pkg;
	localparam int CHANNELS = 8;
	localparam int CODE_W = 12;
	localparam int CH_W = 3;
	localparam int COEF_W = 16;
	localparam int FRAME_W = 32;
	localparam int FRAME_CNT_W = 6;
	// Frame layout, first bit on the wire is bit 31
	localparam int F_OP_HI = 31;
	localparam int F_OP_LO = 28;
	localparam int F_CH_HI = 27;
	localparam int F_CH_LO = 25;
	localparam int F_CAL_SEL = 24;
	localparam int F_DATA_HI = 15;
	localparam int F_DATA_LO = 0;
	localparam int F_CFG_HI = 2;
	localparam int F_CFG_LO = 0;
	localparam int F_MODE = 4;
	// Commands
	localparam logic [3:0] OP_WRITE_CODE = 4'h1;
	localparam logic [3:0] OP_UPDATE_ALL_STROBE = 4'h2;
	localparam logic [3:0] OP_OUTPUT_CONFIG = 4'h3;
	localparam logic [3:0] OP_CALIBRATE_CHANNEL = 4'h4;
	// Output ranges
	localparam logic [1:0] RANGE_2V5 = 2'h0;
	localparam logic [1:0] RANGE_5V = 2'h1;
	localparam logic [1:0] RANGE_10V = 2'h2;
	localparam logic [1:0] RANGE_20V = 2'h3;
	localparam int RANGES = 4;
	localparam logic [2:0] CFG_MAX = 3'h5;
	localparam logic [2:0] CFG_RESET = 3'h2;
	localparam logic MODE_ASYNC = 1'b0;
	localparam logic MODE_SYNC = 1'b1;
	localparam logic [11:0] CODE_RESET = 12'h000;
	localparam logic [15:0] CODE_MAX = 16'h0FFF;
	// Factory constants loaded at reset
	localparam logic [15:0] GAIN_MEASURED = 16'h1000;
	localparam logic [15:0] GAIN_TYPICAL = 16'h1000;
	localparam logic [15:0] OFFSET_MEASURED = 16'h0000;
	localparam logic [15:0] OFFSET_TYPICAL = 16'h0000;
	// Startup sequence length
	localparam int INIT_TIME_NS = 1000;
	localparam int CLK_PERIOD_NS = 4;
	localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		ST_INIT = 2'b01,
		ST_RUN = 2'b10
	} doc_state_e;
endpackage

/* File: test_doc_dac_update_ctrl.sv */
// Self-checking bench for the output update control.
// Link traffic comes from the master model; the checker is bound in.
`timescale 1ns/10ps
`default_nettype none
module test_doc_dac_update_ctrl;
	localparam int INIT = 4;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] rdChannel = 3'h0;
	wire logic linkClk, linkSelN, linkData;
	logic statusIndicator, updateMode, rdMode;
	logic [7:0][11:0] dacCode;
	logic [7:0] dacLoad;
	logic [1:0] rangeLow, rangeHigh;
	logic [2:0] rangeConfig;
	logic [15:0] rdGain, rdOffset;
	int n_errors = 0;
	int tests_run = 0;
	int loadCnt = 0;
	int loadBase = 0;
	int i;
	logic [1:0] lowTbl [6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2, 2'h3};
	logic [2:0] rowCh [4] = '{3'h0, 3'h7, 3'h3, 3'h3};
	logic [11:0] rowCode [4] = '{12'hFFF, 12'h001, 12'h123, 12'h000};
	initial forever #2 sys_clk = ~sys_clk;
	// Load pulses last one cycle, so count them where they have settled
	always @(negedge sys_clk)
		loadCnt <= loadCnt + $countones(dacLoad);
	doc_link_master M (.linkClk(linkClk), .linkSelN(linkSelN),
		.linkData(linkData));
	doc_dac_update_ctrl #(.INIT_CYCLES(INIT)) DUT (.sys_clk(sys_clk),
		.rst(rst), .linkClk(linkClk), .linkSelN(linkSelN),
		.linkData(linkData), .rdChannel(rdChannel),
		.statusIndicator(statusIndicator), .dacCode(dacCode),
		.dacLoad(dacLoad), .rangeLow(rangeLow), .rangeHigh(rangeHigh),
		.updateMode(updateMode), .rangeConfig(rangeConfig),
		.rdGain(rdGain), .rdOffset(rdOffset), .rdMode(rdMode));
	task check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task results;
		if (n_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task frame(input logic [3:0] op, input logic [2:0] ch, input logic sel,
		input logic [15:0] d);
		@(posedge sys_clk);
		#1;
		M.send({op, ch, sel, 8'h00, d}, 32);
		repeat (12) @(posedge sys_clk);
		#1;
	endtask
	initial
	begin
		repeat (5) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		check(16'(statusIndicator), 16'h1);
		check(16'(|dacCode), 16'h0);
		check(16'(rangeConfig), 16'h2);
		repeat (INIT + 5) @(posedge sys_clk);
		#1;
		check(16'(statusIndicator), 16'h0);
		check(rdGain, doc_pkg::GAIN_MEASURED);
		for (i = 0; i < 4; i++)
		begin
			loadBase = loadCnt;
			frame(doc_pkg::OP_WRITE_CODE, rowCh[i], 1'b0, 16'(rowCode[i]));
			check(16'(dacCode[rowCh[i]]), 16'(rowCode[i]));
			check(16'(loadCnt - loadBase), 16'h1);
		end
		// Indicator must stay lit while the aborted frame holds select low
		fork
			M.send({doc_pkg::OP_WRITE_CODE, 3'h5, 25'h0ABC}, 16);
			begin
				repeat (100) @(posedge sys_clk);
				#1;
				check(16'(statusIndicator), 16'h1);
			end
		join
		// Low twelve bits differ from the held code, so a taken write shows
		frame(doc_pkg::OP_WRITE_CODE, 3'h3, 1'b0, 16'h1123);
		check(16'(dacCode[3]), 16'h0);
		loadBase = loadCnt;
		frame(doc_pkg::OP_UPDATE_ALL_STROBE, 3'h0, 1'b0, 16'h0);
		check(16'(dacCode[0]), 16'h0FFF);
		check(16'(loadCnt - loadBase), 16'h0);
		for (i = 0; i < 6; i++)
		begin
			frame(doc_pkg::OP_OUTPUT_CONFIG, 3'h0, 1'b0, 16'(i));
			check(16'(rangeLow), 16'(lowTbl[i]));
			check(16'(rangeHigh), 16'(i > 2 ? 2'h3 : 2'h2));
		end
		frame(doc_pkg::OP_OUTPUT_CONFIG, 3'h0, 1'b0, 16'h0016);
		check(16'(rangeConfig), 16'h5);
		check(16'(updateMode), 16'h1);
		loadBase = loadCnt;
		frame(doc_pkg::OP_WRITE_CODE, 3'h2, 1'b0, 16'h0456);
		check(16'(dacCode[2]), 16'h0);
		frame(doc_pkg::OP_WRITE_CODE, 3'h0, 1'b0, 16'h0321);
		check(16'(dacCode[0]), 16'h0FFF);
		check(16'(loadCnt - loadBase), 16'h0);
		loadBase = loadCnt;
		frame(doc_pkg::OP_UPDATE_ALL_STROBE, 3'h0, 1'b0, 16'h0);
		check(16'(dacCode[2]), 16'h0456);
		check(16'(dacCode[0]), 16'h0321);
		check(16'(dacCode[5]), 16'h0);
		check(16'(loadCnt - loadBase), 16'h8);
		check(16'(rdMode), 16'h1);
		frame(doc_pkg::OP_CALIBRATE_CHANNEL, 3'h0, 1'b0, 16'h0ABC);
		frame(doc_pkg::OP_CALIBRATE_CHANNEL, 3'h0, 1'b1, 16'h0055);
		check(rdGain, 16'h0ABC);
		check(rdOffset, 16'h0055);
		rdChannel = 3'h1;
		repeat (3) @(posedge sys_clk);
		#1;
		check(rdGain, doc_pkg::GAIN_TYPICAL);
		rdChannel = 3'h0;
		frame(doc_pkg::OP_OUTPUT_CONFIG, 3'h0, 1'b0, 16'h0012);
		check(rdGain, doc_pkg::GAIN_MEASURED);
		check(rdOffset, doc_pkg::OFFSET_MEASURED);
		rst = 1'b1;
		@(posedge sys_clk);
		#1;
		rst = 1'b0;
		check(16'(dacCode[2]), 16'h0);
		check(16'(updateMode), 16'h0);
		check(16'(statusIndicator), 16'h1);
		results;
	end
	// Whole run needs about 79 us; more than twice that means a hang
	initial
	begin
		#200000;
		n_errors++;
		results;
	end
endmodule
`default_nettype wire
